// ===== verilog/lsd_pkg.sv
// Constants, field layouts and carrier types of the LO synthesizer divider control.
// Assumes one 25 MHz clock and a VCO edge signal that arrives asynchronously.
package lsd_pkg;

	localparam int REF_W   = 14;
	localparam int SWAL_W  = 5;
	localparam int MAIN_W  = 13;
	localparam int PRESC_P = 8;
	localparam int PRESC_W = 4;
	localparam int HR_W    = 4;
	localparam int ABL_W   = 3;
	localparam int BAND_W  = 5;
	localparam int AMP_W   = 3;
	localparam int PFD_CNT_W = 3;
	localparam int FB_GAP_W  = 17;
	localparam int HR_GAP_W  = 5;

	localparam logic [PRESC_W-1:0]   PRESC_LOAD_PLAIN = PRESC_W'(PRESC_P - 1);
	localparam logic [PRESC_W-1:0]   PRESC_LOAD_SWAL  = PRESC_W'(PRESC_P);
	localparam logic [HR_W-1:0]      HR_MAX       = 4'hC;
	localparam logic [HR_W-1:0]      HR_LOAD_OFS  = 4'h3;
	localparam logic [HR_GAP_W-1:0]  HR_HALF_OFS  = 5'h04;
	localparam logic [HR_W-1:0]      HR_RST       = 4'h0;
	localparam logic [PFD_CNT_W-1:0] BAND_PFD_CYCLES = 3'h5;
	localparam logic [PFD_CNT_W-1:0] BAND_LAST    = 3'h4;
	localparam logic [BAND_W-1:0]    BAND_START   = 5'h10;
	localparam logic [BAND_W-1:0]    BAND_RST     = 5'h10;
	localparam logic [AMP_W-1:0]     AMP_MAX      = 3'h7;
	localparam logic [AMP_W-1:0]     AMP_RST      = 3'h4;
	localparam logic [1:0]           FB_PER_REF   = 2'h1;
	localparam logic [1:0]           FB_CNT_SAT   = 2'h3;

	typedef struct packed {
		logic [REF_W-1:0]  ref_ratio;
		logic [MAIN_W-1:0] main_count;
		logic [SWAL_W-1:0] swallow_count;
		logic [HR_W-1:0]   half_rate_code;
		logic [ABL_W-1:0]  abl_delay;
	} lsd_cfg_type;

	typedef struct packed {
		logic up;
		logic down;
	} lsd_pump_type;

	typedef enum logic [1:0] {
		CAL_IDLE  = 2'b00,
		CAL_BAND  = 2'b01,
		CAL_APPLY = 2'b10
	} lsd_cal_state_type;

endpackage

// ===== verilog/lsd_div_counter.sv
// Reloading down-counter used by the reference, prescaler, main and half-rate dividers of the synthesizer.
// Assumes tick_in and load_in come from logic on clock_in; period is load_in + 1 ticks.
module lsd_div_counter
	import lsd_pkg::*;
#(
	parameter int W = REF_W
)
(
	input  wire logic         clock_in,
	input  wire logic         rst_n_in,
	input  wire logic         tick_in,
	input  wire logic [W-1:0] load_in,
	output logic              pulse_out
);

	logic [W-1:0] count_q;
	logic [W-1:0] count_d;
	logic         pulse_q;
	wire          at_end = tick_in && (count_q == '0);

	// Ratio is taken at the reload, so a new setting acts from the next period
	assign count_d   = at_end ? load_in : (tick_in ? count_q - 1'b1 : count_q);
	assign pulse_out = pulse_q;

	always_ff @(posedge clock_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			count_q <= '0;
			pulse_q <= 1'b0;
		end
		else
		begin
			count_q <= count_d;
			pulse_q <= at_end;
		end
	end

endmodule

// ===== verilog/lsd_synth_ctrl.sv
// Top of the LO synthesizer digital control: dividers, phase detector, calibration.
// Assumes vco_in is an asynchronous VCO edge signal whose edges are at least three
// clocks apart, and that cfg_in is held stable while the loop runs.
module lsd_synth_ctrl
	import lsd_pkg::*;
(
	input  wire logic         clock_in,
	input  wire logic         rst_n_in,
	input  wire lsd_cfg_type  cfg_in,
	input  wire logic         reg3_write_in,
	input  wire logic         vco_in,
	output lsd_pump_type      pump_out,
	output logic              vtune_ref_sel_out,
	output logic [BAND_W-1:0] band_out,
	output logic [AMP_W-1:0]  amplitude_out,
	output logic [HR_W-1:0]   half_rate_out,
	output logic              lo_i_out,
	output logic              lo_q_out
);

	function automatic logic [AMP_W-1:0] amp_of(input logic [BAND_W-1:0] band);
		// Low bands sit at the weak end of the tank, so they get more drive
		amp_of = AMP_MAX - band[BAND_W-1 -: AMP_W];
	endfunction

	function automatic logic [HR_W-1:0] hr_clip(input logic [HR_W-1:0] code);
		hr_clip = (code > HR_MAX) ? HR_MAX : code;
	endfunction

	// VCO edge synchroniser: the first stage feeds only the second
	logic vco_meta_q;
	logic vco_sync_q;
	logic vco_last_q;

	always_ff @(posedge clock_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			vco_meta_q <= 1'b0;
			vco_sync_q <= 1'b0;
			vco_last_q <= 1'b0;
		end
		else
		begin
			vco_meta_q <= vco_in;
			vco_sync_q <= vco_meta_q;
			vco_last_q <= vco_sync_q;
		end
	end

	wire vco_rise   = vco_sync_q & ~vco_last_q;
	wire vco_change = vco_sync_q ^ vco_last_q;

	// Dividers
	logic              ref_pulse;
	logic              presc_pulse;
	logic              fb_pulse;
	logic              hr_pulse;
	logic [SWAL_W-1:0] swal_rem_q;
	logic [HR_W-1:0]   hr_active_q;

	wire [REF_W-1:0]   ref_load   = cfg_in.ref_ratio - 1'b1;
	wire [MAIN_W-1:0]  main_load  = cfg_in.main_count - 1'b1;
	// Modulus P+1 while swallows remain, P afterwards
	wire [PRESC_W-1:0] presc_load = (swal_rem_q != '0) ? PRESC_LOAD_SWAL
	                                                  : PRESC_LOAD_PLAIN;
	wire [HR_W-1:0]    hr_load    = hr_active_q + HR_LOAD_OFS;

	lsd_div_counter #(.W(REF_W)) u_ref_div (
		.clock_in  (clock_in),
		.rst_n_in  (rst_n_in),
		.tick_in   (1'b1),
		.load_in   (ref_load),
		.pulse_out (ref_pulse)
	);

	lsd_div_counter #(.W(PRESC_W)) u_presc (
		.clock_in  (clock_in),
		.rst_n_in  (rst_n_in),
		.tick_in   (vco_rise),
		.load_in   (presc_load),
		.pulse_out (presc_pulse)
	);

	lsd_div_counter #(.W(MAIN_W)) u_main_div (
		.clock_in  (clock_in),
		.rst_n_in  (rst_n_in),
		.tick_in   (presc_pulse),
		.load_in   (main_load),
		.pulse_out (fb_pulse)
	);

	// Counts both VCO edges, so one step is half a VCO period
	lsd_div_counter #(.W(HR_W)) u_half_rate (
		.clock_in  (clock_in),
		.rst_n_in  (rst_n_in),
		.tick_in   (vco_change),
		.load_in   (hr_load),
		.pulse_out (hr_pulse)
	);

	// Swallow count is reloaded at each feedback cycle; needs main > swallow
	always_ff @(posedge clock_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			swal_rem_q <= '0;
		else if (fb_pulse)
			swal_rem_q <= cfg_in.swallow_count;
		else if (presc_pulse && swal_rem_q != '0)
			swal_rem_q <= swal_rem_q - 1'b1;
	end

	// Quadrature divide-by-four as a two-bit Johnson counter
	logic [1:0] quad_q;
	wire  [1:0] quad_d = hr_pulse ? {quad_q[0], ~quad_q[1]} : quad_q;

	// Phase-frequency detector with anti-backlash hold
	lsd_pump_type     pump_q;
	logic [ABL_W-1:0] abl_cnt_q;
	wire  both_on  = pump_q.up & pump_q.down;
	wire  abl_done = both_on && (abl_cnt_q == cfg_in.abl_delay);
	// A new divider pulse wins over the reset of its flag
	wire  up_d     = ref_pulse | (pump_q.up & ~abl_done);
	wire  dn_d     = fb_pulse | (pump_q.down & ~abl_done);
	wire [ABL_W-1:0] abl_cnt_d = (both_on && !abl_done) ? abl_cnt_q + 1'b1 : '0;

	always_ff @(posedge clock_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			quad_q    <= 2'h0;
			pump_q    <= '0;
			abl_cnt_q <= '0;
		end
		else
		begin
			quad_q    <= quad_d;
			pump_q    <= '{up: up_d, down: dn_d};
			abl_cnt_q <= abl_cnt_d;
		end
	end

	// Calibration: binary band search, one bit per reference period
	lsd_cal_state_type    state_q;
	lsd_cal_state_type    state_d;
	logic [BAND_W-1:0]    band_q;
	logic [BAND_W-1:0]    band_d;
	logic [BAND_W-1:0]    trial_q;
	logic [BAND_W-1:0]    trial_d;
	logic [PFD_CNT_W-1:0] pfd_cnt_q;
	logic [PFD_CNT_W-1:0] pfd_cnt_d;
	logic [AMP_W-1:0]     amp_q;
	logic [AMP_W-1:0]     amp_d;
	logic [HR_W-1:0]      hr_d;
	logic                 vtune_q;
	logic                 vtune_d;
	logic [1:0]           fb_cnt_q;

	wire too_fast = fb_cnt_q > FB_PER_REF;
	wire [BAND_W-1:0] band_step = (too_fast ? (band_q & ~trial_q) : band_q) | (trial_q >> 1);
	wire [1:0] fb_cnt_d = ref_pulse ? {1'b0, fb_pulse}
	                    : ((fb_pulse && fb_cnt_q != FB_CNT_SAT) ? fb_cnt_q + 1'b1 : fb_cnt_q);

	always_comb
	begin
		state_d   = state_q;
		band_d    = band_q;
		trial_d   = trial_q;
		pfd_cnt_d = pfd_cnt_q;
		amp_d     = amp_q;
		hr_d      = hr_active_q;
		vtune_d   = vtune_q;
		// Any write restarts, even one that lands mid-calibration
		if (reg3_write_in)
		begin
			state_d   = CAL_BAND;
			band_d    = BAND_START;
			trial_d   = BAND_START;
			pfd_cnt_d = '0;
			vtune_d   = 1'b1;
		end
		else
		begin
			case (state_q)
				CAL_IDLE:
					state_d = CAL_IDLE;
				CAL_BAND:
					if (ref_pulse)
					begin
						band_d    = band_step;
						trial_d   = trial_q >> 1;
						pfd_cnt_d = pfd_cnt_q + 1'b1;
						if (pfd_cnt_q == BAND_LAST)
						begin
							state_d = CAL_APPLY;
							vtune_d = 1'b0;
						end
					end
				CAL_APPLY:
				begin
					amp_d   = amp_of(band_q);
					hr_d    = hr_clip(cfg_in.half_rate_code);
					state_d = CAL_IDLE;
				end
				default:
					state_d = CAL_IDLE;
			endcase
		end
	end

	always_ff @(posedge clock_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			state_q     <= CAL_IDLE;
			band_q      <= BAND_RST;
			trial_q     <= '0;
			pfd_cnt_q   <= '0;
			amp_q       <= AMP_RST;
			hr_active_q <= HR_RST;
			vtune_q     <= 1'b0;
			fb_cnt_q    <= '0;
		end
		else
		begin
			state_q     <= state_d;
			band_q      <= band_d;
			trial_q     <= trial_d;
			pfd_cnt_q   <= pfd_cnt_d;
			amp_q       <= amp_d;
			hr_active_q <= hr_d;
			vtune_q     <= vtune_d;
			fb_cnt_q    <= fb_cnt_d;
		end
	end

	assign pump_out          = pump_q;
	assign vtune_ref_sel_out = vtune_q;
	assign band_out          = band_q;
	assign amplitude_out     = amp_q;
	assign half_rate_out     = hr_active_q;
	assign lo_i_out          = quad_q[1];
	assign lo_q_out          = quad_q[0];

	// Period helpers read only by the checks below
	logic [REF_W-1:0]    ref_gap_q;
	logic [FB_GAP_W-1:0] fb_gap_q;
	logic [HR_GAP_W-1:0] hr_gap_q;
	logic                ref_seen_q;
	logic [1:0]          fb_seen_q;
	logic [1:0]          hr_seen_q;
	// Load that the running reference period was started with
	logic [REF_W-1:0]    ref_load_q;
	logic [REF_W-1:0]    ref_used_q;
	// Ratio copy, so a changed ratio restarts the feedback settling count
	logic [MAIN_W+SWAL_W-1:0] fb_cfg_q;

	always_ff @(posedge clock_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			ref_gap_q  <= '0;
			fb_gap_q   <= '0;
			hr_gap_q   <= '0;
			ref_seen_q <= 1'b0;
			fb_seen_q  <= '0;
			hr_seen_q  <= '0;
			ref_load_q <= '0;
			ref_used_q <= '0;
			fb_cfg_q   <= '0;
		end
		else
		begin
			ref_gap_q  <= ref_pulse ? '0 : ref_gap_q + 1'b1;
			fb_gap_q   <= fb_pulse ? FB_GAP_W'(vco_rise) : fb_gap_q + FB_GAP_W'(vco_rise);
			hr_gap_q   <= hr_pulse ? HR_GAP_W'(vco_change) : hr_gap_q + HR_GAP_W'(vco_change);
			ref_seen_q <= ref_seen_q | ref_pulse;
			fb_seen_q  <= (fb_cfg_q != {cfg_in.main_count, cfg_in.swallow_count}) ? '0
			            : ((fb_pulse && fb_seen_q != FB_CNT_SAT) ? fb_seen_q + 1'b1 : fb_seen_q);
			fb_cfg_q   <= {cfg_in.main_count, cfg_in.swallow_count};
			// Two pulses after apply, so the checked period was loaded with the new code
			hr_seen_q  <= (state_q == CAL_APPLY) ? '0
			            : ((hr_pulse && !hr_seen_q[1]) ? hr_seen_q + 1'b1 : hr_seen_q);
			ref_load_q <= ref_load;
			ref_used_q <= ref_pulse ? ref_load_q : ref_used_q;
		end
	end

	default clocking cb @(posedge clock_in);
	endclocking
	default disable iff (!rst_n_in);

	sequence band_last_s;
		vtune_q && ref_pulse && pfd_cnt_q == BAND_LAST && !reg3_write_in;
	endsequence

	sequence apply_s;
		!vtune_q && state_q == CAL_APPLY && !reg3_write_in;
	endsequence

	band_end_a: assert property (band_last_s |=> apply_s)
		else $error("band selection did not end after five detector cycles");
	band_hold_a: assert property (vtune_q && !(ref_pulse && pfd_cnt_q == BAND_LAST) |=> vtune_q)
		else $error("tuning reference released early");
	cal_start_a: assert property (reg3_write_in |=> vtune_q && pfd_cnt_q == '0 && band_q == BAND_START)
		else $error("register three write did not start calibration");
	cal_apply_a: assert property (apply_s |=> amp_q == amp_of($past(band_q))
		&& hr_active_q == hr_clip($past(cfg_in.half_rate_code)))
		else $error("calibration did not set amplitude and half-rate together");
	ref_period_a: assert property (ref_pulse && ref_seen_q
		|-> ref_gap_q == ref_used_q)
		else $error("reference divider period wrong");
	fb_period_a: assert property (fb_pulse && fb_seen_q == FB_CNT_SAT && $stable(cfg_in)
		|-> fb_gap_q == {cfg_in.main_count, 3'h0} + FB_GAP_W'(cfg_in.swallow_count))
		else $error("feedback ratio is not eight times main plus swallow");
	hr_period_a: assert property (hr_pulse && hr_seen_q[1] && state_q == CAL_IDLE
		|-> hr_gap_q == HR_GAP_W'(hr_active_q) + HR_HALF_OFS)
		else $error("half-rate divider period wrong");
	quad_step_a: assert property (hr_pulse |=> lo_i_out == $past(lo_q_out)
		&& lo_q_out != $past(lo_i_out))
		else $error("quadrature outputs did not step");
	pump_set_a: assert property (ref_pulse |=> pump_out.up)
		else $error("detector missed a reference pulse");
	pump_down_a: assert property (fb_pulse |=> pump_out.down)
		else $error("detector missed a feedback pulse");
	abl_width_a: assert property (both_on && abl_done && !ref_pulse && !fb_pulse
		|=> !pump_q.up && !pump_q.down)
		else $error("anti-backlash pulse too long");
	abl_hold_a: assert property (both_on && !abl_done |=> both_on)
		else $error("anti-backlash pulse too short");
	ref_pulse_a: assert property (ref_pulse && cfg_in.ref_ratio > 1 && $stable(cfg_in.ref_ratio)
		|=> !ref_pulse)
		else $error("reference pulse wider than one cycle");

endmodule

// ===== tb/lsd_vco_model.sv
// Behavioural VCO edge source that drives vco_in of the synthesizer control.
// Assumes the control synchronises vco_out itself, so the phase is unrelated to the clock.
module lsd_vco_model
#(
	parameter int HALF = 160
)
(
	input  wire logic run_in,
	output logic      vco_out
);
	timeunit 1ns;
	timeprecision 1ps;

	// Odd offset keeps the edges away from clock edges; a stopped VCO holds its last level
	initial
	begin
		vco_out = 1'b0;
		#7;
		forever
		begin
			#HALF;
			if (run_in)
				vco_out = ~vco_out;
		end
	end
endmodule

// ===== tb/lsd_synth_ctrl_test.sv
// Self-checking test of the LO synthesizer divider control.
// Assumes lsd_pkg and the design are compiled first; the VCO model feeds vco_in.
module lsd_synth_ctrl_test
	import lsd_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	localparam int LIMIT = 20000;

	logic              clock_in = 1'b0;
	logic              rst_n_in = 1'b0;
	lsd_cfg_type       cfg      = '0;
	logic              reg3     = 1'b0;
	logic              run      = 1'b0;
	logic              vco;
	lsd_pump_type      pump;
	logic              vtune;
	logic [BAND_W-1:0] band;
	logic [AMP_W-1:0]  amp;
	logic [HR_W-1:0]   hr;
	logic              lo_i;
	logic              lo_q;
	int                failures = 0;
	int                checks   = 0;

	always #20 clock_in = ~clock_in;

	lsd_synth_ctrl DUT (.clock_in(clock_in), .rst_n_in(rst_n_in), .cfg_in(cfg),
		.reg3_write_in(reg3), .vco_in(vco), .pump_out(pump), .vtune_ref_sel_out(vtune),
		.band_out(band), .amplitude_out(amp), .half_rate_out(hr), .lo_i_out(lo_i),
		.lo_q_out(lo_q));

	lsd_vco_model VCO (.run_in(run), .vco_out(vco));

	task automatic close_out();
		if (failures == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic chk_val(input logic [15:0] got, input logic [15:0] exp, input string what);
		checks++;
		if (got !== exp)
		begin
			failures++;
			$display("ERROR %0t %s got %h want %h", $time, what, got, exp);
		end
	endtask

	task automatic chk_cnt(input int got, input int lo, input int hi, input string what);
		checks++;
		if (got < lo || got > hi)
		begin
			failures++;
			$display("ERROR %0t %s count %0d not in %0d..%0d", $time, what, got, lo, hi);
		end
	endtask

	function automatic logic pick(input int s);
		case (s)
			0: return vtune;
			1: return pump.down;
			default: return lo_i;
		endcase
	endfunction

	// Counts cycles until the chosen output reaches lvl, sampled at falling edges
	task automatic wait_lvl(input int s, input logic lvl, output int n);
		n = 0;
		while (pick(s) !== lvl && n < LIMIT)
		begin
			@(negedge clock_in);
			n++;
		end
		chk_cnt(n, 0, LIMIT - 1, "wait");
	endtask

	task automatic set_cfg(input int r, input int b, input int a, input int c, input int d);
		@(posedge clock_in);
		cfg <= '{REF_W'(r), MAIN_W'(b), SWAL_W'(a), HR_W'(c), ABL_W'(d)};
	endtask

	// Strobe is the last write, so calibration sees the final settings
	task automatic calibrate(output int h);
		@(posedge clock_in);
		reg3 <= 1'b1;
		@(posedge clock_in);
		reg3 <= 1'b0;
		@(negedge clock_in);
		chk_val(16'(vtune), 16'h0001, "tune switch");
		chk_val(16'(band), 16'h0010, "band start");
		wait_lvl(0, 1'b0, h);
		@(negedge clock_in);
	endtask

	initial
	begin
		int h;
		int l;
		int c;
		int codes[4] = '{0, 5, 12, 15};
		int abls[3] = '{0, 3, 7};
		// Settings stand before release, so the first reference period is already nominal
		set_cfg(25, 6, 5, 0, 0);
		repeat (15) @(posedge clock_in);
		rst_n_in <= 1'b1;
		@(negedge clock_in);
		chk_val(16'(pump), 16'h0000, "pump reset");
		chk_val(16'(vtune), 16'h0000, "tune reset");
		chk_val(16'(band), 16'h0010, "band reset");
		chk_val(16'(amp), 16'h0004, "amp reset");
		chk_val(16'(hr), 16'h0000, "half rate reset");
		chk_val(16'({lo_i, lo_q}), 16'h0000, "lo reset");
		run <= 1'b1;
		// A slow VCO never gives two feedback pulses per reference period
		foreach (codes[i])
		begin
			set_cfg(25, 6, 5, codes[i], 0);
			calibrate(h);
			c = codes[i] > 12 ? 12 : codes[i];
			chk_cnt(h, 99, 127, "band span");
			chk_val(16'(hr), 16'(c), "half rate");
			chk_val(16'(band), 16'h001F, "band slow");
			chk_val(16'(amp), 16'h0000, "amp slow");
			wait_lvl(2, 1'b1, h);
			wait_lvl(2, 1'b0, h);
			wait_lvl(2, 1'b1, h);
			chk_val(16'(lo_q), 16'h0001, "q lead");
			wait_lvl(2, 1'b0, h);
			wait_lvl(2, 1'b1, l);
			chk_cnt(h + l, 16 * (c + 4), 16 * (c + 4), "lo period");
		end
		// Long reference period: every trial band below the top is too fast
		set_cfg(500, 3, 0, 0, 0);
		calibrate(h);
		chk_cnt(h, 1999, 2502, "band span");
		chk_val(16'(band[3:0]), 16'h0000, "band fast");
		foreach (abls[i])
		begin
			set_cfg(25, 6, 5, 0, abls[i]);
			repeat (2)
			begin
				wait_lvl(1, 1'b1, h);
				wait_lvl(1, 1'b0, h);
			end
			wait_lvl(1, 1'b1, h);
			chk_val(16'(pump.up), 16'h0001, "ref flag");
			wait_lvl(1, 1'b0, h);
			wait_lvl(1, 1'b1, l);
			chk_cnt(h, abls[i] + 1, abls[i] + 1, "backlash width");
			chk_cnt(h + l, 424, 424, "feedback period");
		end
		close_out();
	end

	initial
	begin
		repeat (60000) @(posedge clock_in);
		failures++;
		close_out();
	end
endmodule
